/* File: hdl/asp_ctrl.sv */
// host-side controller for a 32k x 8 asynchronous static memory
// assumes synchronous request inputs and testbench resolving the data wire
`timescale 1ns/10ps
module asp_ctrl (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_req,
  input wire logic i_we,
  input wire logic [14:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic [7:0] i_data_in,
  output logic o_busy,
  output logic o_rvalid,
  output logic [7:0] o_rdata,
  output logic [14:0] o_word_address_lines,
  output logic [7:0] o_data_out,
  output logic o_data_oe,
  output logic o_cs_n,
  output logic o_wr_n,
  output logic o_gate_n
);
  typedef struct packed {
    asp_pkg::asp_state_type st;
    logic [3:0] cnt;
    logic busy;
    logic rvalid;
    logic [7:0] rdata;
    logic [14:0] addr;
    logic [7:0] dout;
    logic oe;
    logic cs_n;
    logic wr_n;
    logic gate_n;
  } asp_regs_type;

  asp_regs_type s_r;
  asp_regs_type s_nxt;

  function automatic logic [3:0] asp_cyc(input int n);
    asp_cyc = 4'(n - 1);
  endfunction : asp_cyc

  function automatic logic asp_done(input logic [3:0] c);
    asp_done = (c == asp_pkg::CNT_ZERO);
  endfunction : asp_done

  always_comb begin
    s_nxt = s_r;
    s_nxt.rvalid = 1'b0;
    case (s_r.st)
      asp_pkg::ST_IDLE: begin
        s_nxt.cs_n = 1'b1;
        s_nxt.gate_n = 1'b1;
        s_nxt.wr_n = 1'b1;
        s_nxt.oe = 1'b0;
        s_nxt.busy = 1'b0;
        if (i_req) begin
          s_nxt.busy = 1'b1;
          s_nxt.addr = i_addr;
          s_nxt.cs_n = 1'b0;
          if (i_we) begin
            s_nxt.dout = i_wdata;
            s_nxt.oe = 1'b1;
            s_nxt.st = asp_pkg::ST_WSET;
          end else begin
            s_nxt.gate_n = 1'b0;
            s_nxt.cnt = asp_cyc(asp_pkg::RD_CYC);
            s_nxt.st = asp_pkg::ST_RD;
          end
        end
      end
      asp_pkg::ST_RD: begin
        if (asp_done(s_r.cnt)) begin
          s_nxt.rdata = i_data_in;
          s_nxt.rvalid = 1'b1;
          s_nxt.cs_n = 1'b1;
          s_nxt.gate_n = 1'b1;
          s_nxt.cnt = asp_cyc(asp_pkg::GATE_OFF_CYC);
          s_nxt.st = asp_pkg::ST_GAP;
        end else begin
          s_nxt.cnt = s_r.cnt - 4'h1;
        end
      end
      asp_pkg::ST_WSET: begin
        s_nxt.wr_n = 1'b0;
        s_nxt.cnt = asp_cyc(asp_pkg::WR_PULSE_CYC);
        s_nxt.st = asp_pkg::ST_WPUL;
      end
      asp_pkg::ST_WPUL: begin
        if (asp_done(s_r.cnt)) begin
          s_nxt.wr_n = 1'b1;
          s_nxt.cnt = asp_cyc(asp_pkg::WR_CYC_CYC);
          s_nxt.st = asp_pkg::ST_GAP;
        end else begin
          s_nxt.cnt = s_r.cnt - 4'h1;
        end
      end
      asp_pkg::ST_GAP: begin
        s_nxt.cs_n = 1'b1;
        s_nxt.oe = 1'b0;
        if (asp_done(s_r.cnt)) begin
          s_nxt.busy = 1'b0;
          s_nxt.st = asp_pkg::ST_IDLE;
        end else begin
          s_nxt.cnt = s_r.cnt - 4'h1;
        end
      end
      default: begin
        s_nxt.st = asp_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      s_r <= '{st: asp_pkg::ST_IDLE, cnt: 4'h0, busy: 1'b0, rvalid: 1'b0,
               rdata: 8'h00, addr: 15'h0000, dout: 8'h00, oe: 1'b0,
               cs_n: 1'b1, wr_n: 1'b1, gate_n: 1'b1};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_busy = s_r.busy;
  assign o_rvalid = s_r.rvalid;
  assign o_rdata = s_r.rdata;
  assign o_word_address_lines = s_r.addr;
  assign o_data_out = s_r.dout;
  assign o_data_oe = s_r.oe;
  assign o_cs_n = s_r.cs_n;
  assign o_wr_n = s_r.wr_n;
  assign o_gate_n = s_r.gate_n;

  no_fight_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    !(o_data_oe && !o_gate_n))
    else $error("data driven while gate low");
  rd_wr_high_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    !o_gate_n |-> o_wr_n)
    else $error("write strobe low during read");
  wr_pulse_len_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    $fell(o_wr_n) |-> !o_wr_n [*2])
    else $error("write pulse too short");
  wr_data_hold_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    $rose(o_wr_n) |-> o_data_oe && $stable(o_data_out))
    else $error("data hold lost");
  wr_addr_hold_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    !o_wr_n |-> $stable(o_word_address_lines) && !o_cs_n)
    else $error("address moved");
  wr_setup_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    $fell(o_wr_n) |-> $past(o_data_oe) && !$past(o_cs_n))
    else $error("write setup missing");
  rd_access_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    $fell(o_gate_n) |-> !o_gate_n [*3] ##1 o_rvalid)
    else $error("read timing wrong");
  wr_gap_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    $rose(o_wr_n) |-> o_busy [*2])
    else $error("write cycle gap short");
  idle_desel_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    !o_busy && !$past(o_busy) |-> o_cs_n && !o_data_oe)
    else $error("not deselected");

  rd_sel_len_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    $fell(o_gate_n) |-> !o_cs_n [*3])
    else $error("read select too short");
  rd_addr_hold_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    !o_cs_n && !$past(o_cs_n) |-> $stable(o_word_address_lines))
    else $error("address moved while selected");
  cs_with_req_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    $fell(o_cs_n) |-> $rose(o_busy))
    else $error("select fell outside a take");
  addr_launch_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    $fell(o_cs_n) |-> o_word_address_lines == $past(i_addr))
    else $error("address not launched with select");
  wr_data_launch_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    $rose(o_data_oe) |-> o_data_out == $past(i_wdata))
    else $error("write data not launched with drive");
  rvalid_end_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    o_rvalid |-> $rose(o_gate_n) && $rose(o_cs_n))
    else $error("read not closed at data strobe");
  rvalid_pulse_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    o_rvalid |=> !o_rvalid && !o_busy)
    else $error("read valid pulse too long");
  rdata_hold_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    !o_rvalid |-> $stable(o_rdata))
    else $error("read data moved");
  rd_capture_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    o_rvalid |-> o_rdata == $past(i_data_in))
    else $error("read data not captured");
  gate_off_gap_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    $rose(o_gate_n) |-> !o_data_oe [*2])
    else $error("drive too soon after gate off");
  wr_sel_end_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    $rose(o_wr_n) |-> !o_cs_n)
    else $error("strobe does not end the write");
  wr_sel_setup_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    $rose(o_wr_n) |-> !$past(o_cs_n, 3))
    else $error("select too short before write end");
  wr_addr_setup_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    $rose(o_wr_n) |-> o_word_address_lines == $past(o_word_address_lines, 3))
    else $error("address setup to write end short");
  wr_data_setup_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    $rose(o_wr_n) |-> o_data_out == $past(o_data_out, 3) && $past(o_data_oe, 3))
    else $error("data setup to write end short");
  wr_oe_release_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    $fell(o_data_oe) |-> o_wr_n && $past(o_wr_n))
    else $error("data released before write end");
  wr_pulse_end_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    $fell(o_wr_n) |-> ##2 o_wr_n)
    else $error("write pulse not ended");
  idle_strobes_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    !o_busy |-> o_wr_n && o_gate_n)
    else $error("strobe low while idle");
  rd_wr_strobe_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    !o_cs_n && !o_data_oe |-> o_wr_n)
    else $error("write strobe low in read cycle");
  wr_oe_window_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    o_data_oe |-> !o_cs_n)
    else $error("data driven while deselected");
  wr_strobe_data_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    !o_wr_n |-> o_data_oe)
    else $error("strobe low without data");
  busy_len_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    $rose(o_busy) |-> o_busy [*4])
    else $error("cycle ended too soon");
  cs_high_gap_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    $rose(o_cs_n) |-> o_cs_n [*2])
    else $error("select gap too short");
endmodule : asp_ctrl

/* File: hdl/asp_pkg.sv */
// constants for the byte-wide static memory controller
// assumes a 200 MHz clock and an asynchronous 32k x 8 memory on the pins
package asp_pkg;
  localparam int ADDR_W = 15;
  localparam int DATA_W = 8;
  localparam int CLK_PS = 5000;
  // times in picoseconds as printed
  localparam int WR_PULSE_PS = 7000;
  localparam int WR_DATA_SETUP_PS = 6500;
  localparam int WR_CYCLE_PS = 10000;
  localparam int RD_ACCESS_PS = 10000;
  localparam int RD_GATE_PS = 5000;
  localparam int GATE_OFF_PS = 5000;
  // least times round up
  localparam int WR_PULSE_CYC = (WR_PULSE_PS + CLK_PS - 1) / CLK_PS;
  localparam int WR_CYC_CYC = (WR_CYCLE_PS + CLK_PS - 1) / CLK_PS;
  // read data sampled strictly after the access time
  localparam int RD_CYC = RD_ACCESS_PS / CLK_PS + 1;
  localparam int GATE_OFF_CYC = (GATE_OFF_PS + CLK_PS - 1) / CLK_PS;
  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_RD = 5'h02,
    ST_WSET = 5'h04,
    ST_WPUL = 5'h08,
    ST_GAP = 5'h10
  } asp_state_type;
endpackage : asp_pkg

/* File: verif/asp_sram_model.sv */
// behavioural 32k x 8 asynchronous static memory
// assumes the bench resolves the shared data wire
`timescale 1ns/10ps
module asp_sram_model (
  input wire logic [14:0] i_addr,
  input wire logic [7:0] i_din,
  input wire logic i_cs_n,
  input wire logic i_wr_n,
  input wire logic i_gate_n,
  output logic [7:0] o_dout,
  output logic o_oe
);
  logic [7:0] mem [0:32767];
  // write lands at the end of the select and strobe overlap
  always @(posedge i_wr_n or posedge i_cs_n) begin
    if (!i_cs_n || !i_wr_n) mem[i_addr] = i_din;
  end
  assign #10 o_dout = mem[i_addr];
  assign o_oe = !i_cs_n && i_wr_n && !i_gate_n;
endmodule : asp_sram_model

/* File: verif/tb.sv */
// self-checking bench for the static memory controller
// assumes asp_ctrl and asp_sram_model are compiled first
`timescale 1ns/10ps
module tb;
  logic i_clk = 0, i_nrst = 0, i_req = 0, i_we = 0;
  logic [14:0] i_addr = 15'h0000, a;
  logic [7:0] i_wdata = 8'h00, dout, mdout, last_r = 8'h00, bus;
  logic busy, rv, oe, cs_n, wr_n, gate_n, moe;
  logic [7:0] rdata;
  int error_cnt = 0, checks_done = 0, cyc = 0, rv_cnt = 0, n;
  logic [31:0] rows [6] = '{32'h1_0000_a5, 32'h1_7fff_5a, 32'h0_7fff_5a,
    32'h0_0000_a5, 32'h1_1234_3c, 32'h0_1234_3c};
  assign bus = oe ? dout : (moe ? mdout : ~last_r);
  asp_ctrl asp_ctrl_inst (.i_clk(i_clk), .i_nrst(i_nrst), .i_req(i_req), .i_we(i_we),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_data_in(bus), .o_busy(busy), .o_rvalid(rv),
    .o_rdata(rdata), .o_word_address_lines(a), .o_data_out(dout), .o_data_oe(oe),
    .o_cs_n(cs_n), .o_wr_n(wr_n), .o_gate_n(gate_n));
  asp_sram_model asp_sram_model_inst (.i_addr(a), .i_din(bus), .i_cs_n(cs_n),
    .i_wr_n(wr_n), .i_gate_n(gate_n), .o_dout(mdout), .o_oe(moe));
  initial forever #2.5 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (oe || moe) last_r <= bus;
    if (rv === 1'b1) rv_cnt <= rv_cnt + 1;
    if (cyc == 2000) begin
      error_cnt++;
      complete_run();
    end
  end
  always @(negedge i_clk) if (oe === 1'b1 && moe === 1'b1) chk(8'h00, 8'h01);
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic op(input logic we, input logic [14:0] ad, input logic [7:0] d);
    @(negedge i_clk);
    {i_req, i_we, i_addr, i_wdata} = {1'b1, we, ad, d};
    @(negedge i_clk);
    i_req = 0;
    @(negedge i_clk);
    while (busy !== 1'b0) @(negedge i_clk);
  endtask : op
  task automatic complete_run();
    $display("errors %0d checks %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : complete_run
  initial begin
    repeat (3) @(negedge i_clk);
    i_nrst = 1;
    foreach (rows[k]) begin
      n = rv_cnt;
      op(rows[k][24], rows[k][22:8], rows[k][7:0]);
      if (!rows[k][24]) begin
        chk(rdata, rows[k][7:0]);
      end
      chk(8'(rv_cnt - n), {7'h00, !rows[k][24]});
    end
    // second request while busy must be dropped
    @(negedge i_clk);
    {i_req, i_we, i_addr, i_wdata} = {1'b1, 1'b1, 15'h0001, 8'h11};
    repeat (2) @(negedge i_clk);
    i_wdata = 8'hee;
    @(negedge i_clk);
    i_req = 0;
    repeat (6) @(negedge i_clk);
    op(0, 15'h0001, 8'h00);
    chk(rdata, 8'h11);
    // mid-run reset, strobes released, contents kept
    i_nrst = 0;
    repeat (2) @(negedge i_clk);
    chk({3'h0, cs_n, wr_n, gate_n, oe, busy}, 8'h1c);
    i_nrst = 1;
    op(0, 15'h0000, 8'h00);
    chk(rdata, 8'ha5);
    complete_run();
  end
endmodule : tb
